/* File: include/event_timer_pkg.sv */
// Constants shared by the eight-bit event timer and its count clock generator
package event_timer_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [15:0] IDX_TIMER_MODE_CONTROL = 16'hff43;
    localparam logic [15:0] IDX_PORT3_DIRECTION    = 16'hff23;
    localparam logic [15:0] IDX_COUNTER_VALUE      = 16'hff1f;
    localparam logic [15:0] IDX_CLOCK_SELECTION    = 16'hff8c;
    localparam logic [15:0] IDX_COMPARE_VALUE      = 16'hff41;
    localparam logic [15:0] IDX_PORT1_DIRECTION    = 16'hff21;
    localparam logic [15:0] IDX_PORT3_LATCH        = 16'hff03;
    localparam int          ADDR_W                 = 18;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_TIMER_MODE_CONTROL = 8'h00;
    localparam logic [7:0] RST_DIRECTION          = 8'hff;
    localparam logic [7:0] RST_COUNTER_VALUE      = 8'h00;
    localparam logic [7:0] RST_COMPARE_VALUE      = 8'h00;
    localparam logic [2:0] RST_CLOCK_SELECTION    = 3'h0;
    localparam logic [7:0] RST_PORT_LATCH         = 8'h00;

    // ************************************************************
    // Mode control field positions
    // ************************************************************
    localparam int BIT_COUNT_ENABLE  = 7;
    localparam int BIT_MODE_SELECT   = 6;
    localparam int BIT_FF_SET_REQ    = 3;
    localparam int BIT_FF_CLEAR_REQ  = 2;
    localparam int BIT_INVERT_POL    = 1;
    localparam int BIT_OUTPUT_ENABLE = 0;
    localparam logic [7:0] MODE_READ_MASK = 8'hc3;
    localparam int BIT_SHARED_PIN    = 3;
    localparam int CLK_SEL_W         = 3;

    // ************************************************************
    // Count clock selection codes
    // ************************************************************
    typedef enum logic [2:0] {
        CLK_EVENT_FALL = 3'h0,
        CLK_EVENT_RISE = 3'h1,
        CLK_PCLK_DIV1  = 3'h2,
        CLK_PCLK_DIV2  = 3'h3,
        CLK_PCLK_DIV16 = 3'h4,
        CLK_PCLK_DIV64 = 3'h5,
        CLK_PCLK_DIV256 = 3'h6,
        CLK_AUX_TICK   = 3'h7
    } clk_sel_t;

    localparam logic [7:0] PRE_MASK_DIV2   = 8'h01;
    localparam logic [7:0] PRE_MASK_DIV16  = 8'h0f;
    localparam logic [7:0] PRE_MASK_DIV64  = 8'h3f;
    localparam logic [7:0] PRE_MASK_DIV256 = 8'hff;
    localparam logic [7:0] COUNT_MAX       = 8'hff;

endpackage

/* File: include/count_clk_if.sv */
// Carrier between the timer core and its count clock generator
`timescale 1ns/100ps
interface count_clk_if;
    logic [2:0] sel;
    logic       run;
    logic       event_level;
    logic       aux_tick;
    logic       tick;

    modport gen  (input sel, input run, input event_level, input aux_tick, output tick);
    modport core (output sel, output run, output event_level, output aux_tick, input tick);
endinterface

/* File: src/count_clock_gen.sv */
// Count clock generator: prescaled pclk, event pin edges or auxiliary tick
`timescale 1ns/100ps
module count_clock_gen
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    count_clk_if.gen   cc
);

    logic [7:0] pre_reg;
    logic [7:0] pre_next;
    logic       ev_prev_reg;
    logic       ev_prev_next;
    logic       tick_reg;
    logic       tick_next;

    // Prescaler restarts with the counter, so the first count lands a full period late at most
    always_comb
    begin
        pre_next     = cc.run ? 8'(pre_reg + 8'h01) : 8'h00;
        ev_prev_next = cc.event_level;
        tick_next    = 1'b0;
        if (cc.run)
        begin
            unique case (event_timer_pkg::clk_sel_t'(cc.sel))
                event_timer_pkg::CLK_EVENT_FALL:  tick_next = ev_prev_reg & ~cc.event_level;
                event_timer_pkg::CLK_EVENT_RISE:  tick_next = ~ev_prev_reg & cc.event_level;
                event_timer_pkg::CLK_PCLK_DIV1:   tick_next = 1'b1;
                event_timer_pkg::CLK_PCLK_DIV2:
                    tick_next = (pre_reg & event_timer_pkg::PRE_MASK_DIV2) == event_timer_pkg::PRE_MASK_DIV2;
                event_timer_pkg::CLK_PCLK_DIV16:
                    tick_next = (pre_reg & event_timer_pkg::PRE_MASK_DIV16) == event_timer_pkg::PRE_MASK_DIV16;
                event_timer_pkg::CLK_PCLK_DIV64:
                    tick_next = (pre_reg & event_timer_pkg::PRE_MASK_DIV64) == event_timer_pkg::PRE_MASK_DIV64;
                event_timer_pkg::CLK_PCLK_DIV256:
                    tick_next = pre_reg == event_timer_pkg::PRE_MASK_DIV256;
                event_timer_pkg::CLK_AUX_TICK:    tick_next = cc.aux_tick;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_reg     <= 8'h00;
            ev_prev_reg <= 1'b0;
            tick_reg    <= 1'b0;
        end
        else
        begin
            pre_reg     <= pre_next;
            ev_prev_reg <= ev_prev_next;
            tick_reg    <= tick_next;
        end
    end

    assign cc.tick = tick_reg;

endmodule // count_clock_gen

/* File: src/eight_bit_event_timer.sv */
// Eight-bit timer and event counter with compare, output flip-flop, PWM and APB registers
//
// Operation
// - Count enable 0 clears and stops counter; 1 starts counting.
// - Mode bit 6: 0 clear-and-restart on match, 1 free-running PWM.
// - Preset field: 00 no change, 01 clear, 10 set, 11 prohibited.
// - Set and clear request bits 2 and 3 are write-only, read zero.
// - Set and clear requests ignored in PWM mode.
// - Bit 1: inversion enable outside PWM, active-low select in PWM.
// - Output enable 0 holds output low; 1 passes flip-flop or PWM level.
// - In PWM mode clearing count enable forces output inactive.
// - Mode, preset, polarity and enable reach the output regardless of counting.
// - Direction registers reset to all ones; 1 input, 0 output.
// - Interval mode: match clears counter, keeps counting, raises interrupt.
// - Interval mode: match period is compare plus one count clocks.
// - Count clock chosen by three-bit selection field, bits 0 to 2.
// - Event counting on falling (code 0) or rising (code 1) pin edge.
// - Square wave: flip-flop toggles on each match, then counter clears.
// - Square-wave frequency is one over twice period times compare plus one.
// - PWM active at overflow, inactive at compare match; period 256 clocks.
// - No interrupt on PWM match; every other match interrupts.
// - Counter increments on count clock; reset clears it to zero.
// - PWM compare takes effect at overflow; late writes wait one more overflow.
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
module eight_bit_event_timer
(
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic [event_timer_pkg::ADDR_W-1:0] paddr,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [31:0]                        pwdata,
    output      logic [31:0]                        prdata,
    output      logic                               pready,
    output      logic                               pslverr,
    input  wire logic                               shared_pin_in,
    output      logic                               shared_pin_out,
    output      logic                               shared_pin_oe,
    input  wire logic                               aux_count_tick,
    output      logic                               match_interrupt
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]  mode_reg,     mode_next;
    logic [2:0]  clk_sel_reg,  clk_sel_next;
    logic [7:0]  compare_reg,  compare_next;
    logic [7:0]  port3_dir_reg, port3_dir_next;
    logic [7:0]  port1_dir_reg, port1_dir_next;
    logic [7:0]  latch_reg,    latch_next;
    logic [31:0] prdata_reg,   prdata_next;
    logic        pready_reg,   pready_next;
    logic        pslverr_reg,  pslverr_next;

    logic [7:0]  count_reg,    count_next;
    logic [7:0]  pwm_cmp_reg,  pwm_cmp_next;
    logic        late_reg,     late_next;
    logic        out_ff_reg,   out_ff_next;
    logic        pwm_act_reg,  pwm_act_next;
    logic        irq_reg,      irq_next;
    logic        pin_out_reg,  pin_out_next;
    logic        pin_oe_reg,   pin_oe_next;

    logic        ev_meta_reg;
    logic        ev_sync_reg;

    logic        wr_en;
    logic        count_en;
    logic        pwm_mode;
    logic        match;
    logic [7:0]  count_inc;
    logic        timer_out;

    count_clk_if cc ();

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic addr_is(input logic [event_timer_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
        addr_is = a == {idx, 2'b00};
    endfunction

    function automatic logic addr_mapped(input logic [event_timer_pkg::ADDR_W-1:0] a);
        addr_mapped = addr_is(a, event_timer_pkg::IDX_TIMER_MODE_CONTROL) |
                      addr_is(a, event_timer_pkg::IDX_PORT3_DIRECTION)    |
                      addr_is(a, event_timer_pkg::IDX_COUNTER_VALUE)      |
                      addr_is(a, event_timer_pkg::IDX_CLOCK_SELECTION)    |
                      addr_is(a, event_timer_pkg::IDX_COMPARE_VALUE)      |
                      addr_is(a, event_timer_pkg::IDX_PORT1_DIRECTION)    |
                      addr_is(a, event_timer_pkg::IDX_PORT3_LATCH);
    endfunction

    // ************************************************************
    // Event pin synchroniser
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_meta_reg <= 1'b0;
            ev_sync_reg <= 1'b0;
        end
        else
        begin
            ev_meta_reg <= shared_pin_in;
            ev_sync_reg <= ev_meta_reg;
        end
    end

    assign count_en       = mode_reg[event_timer_pkg::BIT_COUNT_ENABLE];
    assign pwm_mode       = mode_reg[event_timer_pkg::BIT_MODE_SELECT];
    assign cc.sel         = clk_sel_reg;
    assign cc.run         = count_en;
    assign cc.event_level = ev_sync_reg;
    assign cc.aux_tick    = aux_count_tick;

    count_clock_gen u_count_clock_gen
    (
        .pclk    (pclk),
        .presetn (presetn),
        .cc      (cc)
    );

    // ************************************************************
    // APB slave and registers
    // ************************************************************
    // One access cycle: pready rises in the access phase; unmapped addresses answer with pslverr
    assign wr_en = psel & penable & pready_reg & pwrite & ~pslverr_reg;

    always_comb
    begin
        mode_next      = mode_reg;
        clk_sel_next   = clk_sel_reg;
        compare_next   = compare_reg;
        port3_dir_next = port3_dir_reg;
        port1_dir_next = port1_dir_reg;
        latch_next     = latch_reg;
        prdata_next    = prdata_reg;
        pready_next    = 1'b0;
        pslverr_next   = 1'b0;
        if (psel && !penable)
        begin
            pready_next  = 1'b1;
            pslverr_next = ~addr_mapped(paddr);
            prdata_next  = 32'h0000_0000;
            if (addr_is(paddr, event_timer_pkg::IDX_TIMER_MODE_CONTROL))
                prdata_next[7:0] = mode_reg & event_timer_pkg::MODE_READ_MASK;
            if (addr_is(paddr, event_timer_pkg::IDX_PORT3_DIRECTION))
                prdata_next[7:0] = port3_dir_reg;
            if (addr_is(paddr, event_timer_pkg::IDX_COUNTER_VALUE))
                prdata_next[7:0] = count_reg;
            if (addr_is(paddr, event_timer_pkg::IDX_CLOCK_SELECTION))
                prdata_next[2:0] = clk_sel_reg;
            if (addr_is(paddr, event_timer_pkg::IDX_COMPARE_VALUE))
                prdata_next[7:0] = compare_reg;
            if (addr_is(paddr, event_timer_pkg::IDX_PORT1_DIRECTION))
                prdata_next[7:0] = port1_dir_reg;
            if (addr_is(paddr, event_timer_pkg::IDX_PORT3_LATCH))
                prdata_next[7:0] = latch_reg;
        end
        else if (psel && penable && !pready_reg)
        begin
            pready_next  = 1'b1;
            pslverr_next = pslverr_reg;
        end
        if (wr_en)
        begin
            // Request bits act on the write itself and are never stored, so they read back as zero
            if (addr_is(paddr, event_timer_pkg::IDX_TIMER_MODE_CONTROL))
                mode_next = pwdata[7:0] & event_timer_pkg::MODE_READ_MASK;
            if (addr_is(paddr, event_timer_pkg::IDX_PORT3_DIRECTION))
                port3_dir_next = pwdata[7:0];
            if (addr_is(paddr, event_timer_pkg::IDX_CLOCK_SELECTION))
                clk_sel_next = pwdata[event_timer_pkg::CLK_SEL_W-1:0];
            if (addr_is(paddr, event_timer_pkg::IDX_COMPARE_VALUE))
                compare_next = pwdata[7:0];
            if (addr_is(paddr, event_timer_pkg::IDX_PORT1_DIRECTION))
                port1_dir_next = pwdata[7:0];
            if (addr_is(paddr, event_timer_pkg::IDX_PORT3_LATCH))
                latch_next = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg      <= event_timer_pkg::RST_TIMER_MODE_CONTROL;
            clk_sel_reg   <= event_timer_pkg::RST_CLOCK_SELECTION;
            compare_reg   <= event_timer_pkg::RST_COMPARE_VALUE;
            port3_dir_reg <= event_timer_pkg::RST_DIRECTION;
            port1_dir_reg <= event_timer_pkg::RST_DIRECTION;
            latch_reg     <= event_timer_pkg::RST_PORT_LATCH;
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
        end
        else
        begin
            mode_reg      <= mode_next;
            clk_sel_reg   <= clk_sel_next;
            compare_reg   <= compare_next;
            port3_dir_reg <= port3_dir_next;
            port1_dir_reg <= port1_dir_next;
            latch_reg     <= latch_next;
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
        end
    end

    // ************************************************************
    // Counter, compare and output flip-flops
    // ************************************************************
    assign count_inc = 8'(count_reg + 8'h01);
    assign match     = cc.tick & (count_reg == compare_reg);

    always_comb
    begin
        count_next   = count_reg;
        pwm_cmp_next = pwm_cmp_reg;
        late_next    = late_reg;
        out_ff_next  = out_ff_reg;
        pwm_act_next = pwm_act_reg;
        irq_next     = 1'b0;

        // A PWM compare write landing while the counter sits at its maximum waits one extra overflow
        if (wr_en && pwm_mode && addr_is(paddr, event_timer_pkg::IDX_COMPARE_VALUE))
            late_next = count_reg == event_timer_pkg::COUNT_MAX;

        if (!count_en)
        begin
            count_next   = event_timer_pkg::RST_COUNTER_VALUE;
            pwm_act_next = 1'b0;
            late_next    = 1'b0;
        end
        else if (cc.tick)
        begin
            if (pwm_mode)
            begin
                count_next = count_inc;
                if (count_reg == event_timer_pkg::COUNT_MAX)
                begin
                    if (late_reg)
                    begin
                        late_next    = 1'b0;
                        pwm_act_next = pwm_cmp_reg != 8'h00;
                    end
                    else
                    begin
                        pwm_cmp_next = compare_reg;
                        pwm_act_next = compare_reg != 8'h00;
                    end
                end
                else if (count_inc == pwm_cmp_reg)
                    pwm_act_next = 1'b0;
            end
            else if (match)
            begin
                count_next = 8'h00;
                irq_next   = 1'b1;
                if (mode_reg[event_timer_pkg::BIT_INVERT_POL])
                    out_ff_next = ~out_ff_reg;
            end
            else
                count_next = count_inc;
        end

        // Preset acts at once, counting or not; the prohibited 11 code is ignored
        if (wr_en && addr_is(paddr, event_timer_pkg::IDX_TIMER_MODE_CONTROL) &&
            !pwdata[event_timer_pkg::BIT_MODE_SELECT])
        begin
            if (pwdata[event_timer_pkg::BIT_FF_SET_REQ] && !pwdata[event_timer_pkg::BIT_FF_CLEAR_REQ])
                out_ff_next = 1'b1;
            else if (!pwdata[event_timer_pkg::BIT_FF_SET_REQ] && pwdata[event_timer_pkg::BIT_FF_CLEAR_REQ])
                out_ff_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_reg   <= event_timer_pkg::RST_COUNTER_VALUE;
            pwm_cmp_reg <= event_timer_pkg::RST_COMPARE_VALUE;
            late_reg    <= 1'b0;
            out_ff_reg  <= 1'b0;
            pwm_act_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end
        else
        begin
            count_reg   <= count_next;
            pwm_cmp_reg <= pwm_cmp_next;
            late_reg    <= late_next;
            out_ff_reg  <= out_ff_next;
            pwm_act_reg <= pwm_act_next;
            irq_reg     <= irq_next;
        end
    end

    // ************************************************************
    // Timer output and shared pin
    // ************************************************************
    // The pin merges timer output with the port latch, so the latch must stay low in output use
    always_comb
    begin
        if (!mode_reg[event_timer_pkg::BIT_OUTPUT_ENABLE])
            timer_out = 1'b0;
        else if (pwm_mode)
            timer_out = pwm_act_reg ^ mode_reg[event_timer_pkg::BIT_INVERT_POL];
        else
            timer_out = out_ff_reg;
        pin_out_next = timer_out | latch_reg[event_timer_pkg::BIT_SHARED_PIN];
        pin_oe_next  = ~port3_dir_reg[event_timer_pkg::BIT_SHARED_PIN];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_reg <= 1'b0;
            pin_oe_reg  <= 1'b0;
        end
        else
        begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg  <= pin_oe_next;
        end
    end

    assign prdata          = prdata_reg;
    assign pready          = pready_reg;
    assign pslverr         = pslverr_reg;
    assign shared_pin_out  = pin_out_reg;
    assign shared_pin_oe   = pin_oe_reg;
    assign match_interrupt = irq_reg;

endmodule // eight_bit_event_timer

/* File: testbench/timer_props.sv */
// Port-level assertions for the eight-bit event timer
`timescale 1ns/100ps
module timer_props
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [17:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        shared_pin_oe,
    input wire logic        match_interrupt
);
    // ************************************************************
    // Bus and pin properties
    // ************************************************************
    localparam logic [17:0] a_mode = {event_timer_pkg::IDX_TIMER_MODE_CONTROL, 2'b00};
    localparam logic [17:0] a_dir3 = {event_timer_pkg::IDX_PORT3_DIRECTION, 2'b00};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done(w, a);
        psel && penable && pready && pwrite == w && paddr == a;
    endsequence
    property p_oe;
        logic b;
        (s_done(1'b1, a_dir3), b = pwdata[3]) |-> ##2 shared_pin_oe == !b;
    endproperty
    chk_ready_setup: assert property (s_setup |=> pready && penable)
        else $error("no ready in access phase");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    chk_req_zero: assert property (s_done(1'b0, a_mode) |-> prdata[3:2] == 2'b00)
        else $error("request bits read nonzero");
    chk_irq_pulse: assert property (match_interrupt |=> !match_interrupt)
        else $error("interrupt wider than one cycle");
    chk_dir_oe: assert property (p_oe)
        else $error("pin enable disagrees with direction");
    chk_data_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits nonzero");
endmodule // timer_props

bind eight_bit_event_timer timer_props u_props (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .shared_pin_oe, .match_interrupt);

/* File: testbench/event_source.sv */
// Event pin source: toggles every eight clocks while enabled
`timescale 1ns/100ps
module event_source
(
    input  wire logic pclk,
    input  wire logic en,
    output      logic level
);
    int k = 0;
    initial level = 1'b0;
    // Stands still outside bursts so no stray edges reach the counter
    always @(posedge pclk)
        if (en)
        begin
            k <= k + 1;
            if (k % 8 == 7)
                level <= ~level;
        end
endmodule // event_source

/* File: testbench/eight_bit_event_timer_tb.sv */
// Self-checking bench for the eight-bit event timer
`timescale 1ns/100ps
module eight_bit_event_timer_tb;
    // ************************************************************
    // Stimulus, expectations and checks
    // ************************************************************
    localparam logic [15:0] r_mode = event_timer_pkg::IDX_TIMER_MODE_CONTROL;
    localparam logic [15:0] r_dir3 = event_timer_pkg::IDX_PORT3_DIRECTION;
    localparam logic [15:0] r_cmp = event_timer_pkg::IDX_COMPARE_VALUE;
    localparam logic [15:0] r_sel = event_timer_pkg::IDX_CLOCK_SELECTION;
    logic pclk, presetn, psel, penable, pwrite, ev_en, aux_tick, err;
    logic pready, pslverr, pin_out, pin_oe, ev_level, irq;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    wire pin_wire = pin_oe ? pin_out : ev_level;
    int n_errors = 0, checked = 0, n_irq = 0, c, n, q;
    logic [15:0] ra[7] = '{r_mode, r_dir3, event_timer_pkg::IDX_COUNTER_VALUE, r_sel, r_cmp,
        event_timer_pkg::IDX_PORT1_DIRECTION, event_timer_pkg::IDX_PORT3_LATCH};
    logic [7:0] rv[7] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
    int dv[3] = '{16, 2, 1};
    eight_bit_event_timer DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .shared_pin_in(pin_wire), .shared_pin_out(pin_out), .shared_pin_oe(pin_oe),
        .aux_count_tick(aux_tick), .match_interrupt(irq));
    event_source src (.pclk, .en(ev_en), .level(ev_level));
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Holds the request until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_for(input logic pin, input logic v, output int c);
        for (c = 1; c < 3000; c++)
        begin
            @(posedge pclk);
            if ((pin ? pin_out : irq) === v)
                break;
        end
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial
    begin
        #(40 * 40000);
        n_errors++;
        final_report;
    end
    initial seed = 32'h4406;
    initial aux_tick = 1'b0;
    always @(posedge pclk)
    begin
        seed <= lf(seed);
        aux_tick <= seed[0];
        if (irq === 1'b1)
            n_irq++;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, ev_en, paddr, pwdata} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i])
        begin
            apb(1'b0, ra[i], 8'h00);
            chk(rd, {24'h0, rv[i]});
        end
        apb(1'b0, 16'h0001, 8'h00);
        chk(err, 1'b1);
        apb(1'b1, r_mode, 8'h08);
        apb(1'b0, r_mode, 8'h00);
        chk(rd, 32'h0);
        $display("registers done");
        n = 1 + seed[3:0];
        apb(1'b1, r_cmp, n[7:0]);
        foreach (dv[j])
        begin
            apb(1'b1, r_sel, 8'(4 - j));
            apb(1'b0, r_sel, 8'h00);
            chk(rd, 32'(4 - j));
            apb(1'b1, r_mode, 8'h80);
            wait_for(1'b0, 1'b1, c);
            wait_for(1'b0, 1'b1, c);
            chk(c, (n + 1) * dv[j]);
            apb(1'b1, r_mode, 8'h00);
            apb(1'b0, event_timer_pkg::IDX_COUNTER_VALUE, 8'h00);
            chk(rd, 32'h0);
        end
        $display("interval done");
        apb(1'b1, r_dir3, 8'hf7);
        apb(1'b1, event_timer_pkg::IDX_PORT3_LATCH, 8'h00);
        apb(1'b1, r_mode, 8'h02);
        apb(1'b1, r_mode, 8'h03);
        apb(1'b1, r_mode, 8'h0b);
        repeat (3) @(posedge pclk);
        chk(pin_out, 1'b1);
        apb(1'b1, r_mode, 8'h07);
        repeat (3) @(posedge pclk);
        chk(pin_out, 1'b0);
        apb(1'b1, r_mode, 8'h83);
        wait_for(1'b1, 1'b1, c);
        wait_for(1'b1, 1'b0, c);
        chk(c, n + 1);
        apb(1'b1, r_mode, 8'h0b);
        apb(1'b1, r_mode, 8'h02);
        repeat (3) @(posedge pclk);
        chk(pin_out, 1'b0);
        $display("square wave done");
        for (int pol = 0; pol < 2; pol++)
        begin
            n = 1 + seed[6:0];
            q = n_irq;
            apb(1'b1, r_mode, {6'h10, pol[0], 1'b0});
            apb(1'b1, r_mode, {6'h10, pol[0], 1'b1});
            apb(1'b1, r_cmp, n[7:0]);
            apb(1'b1, r_mode, {6'h30, pol[0], 1'b1});
            wait_for(1'b1, !pol[0], c);
            wait_for(1'b1, pol[0], c);
            chk(c, n);
            chk(n_irq, q);
            apb(1'b1, r_mode, {6'h10, pol[0], 1'b1});
            repeat (3) @(posedge pclk);
            chk(pin_out, pol[0]);
        end
        apb(1'b1, r_mode, 8'h47);
        apb(1'b1, r_mode, 8'h03);
        repeat (3) @(posedge pclk);
        chk(pin_out, 1'b1);
        $display("pwm done");
        apb(1'b1, r_dir3, 8'hff);
        apb(1'b1, r_mode, 8'h00);
        apb(1'b1, r_cmp, 8'h02);
        for (int code = 0; code < 2; code++)
        begin
            apb(1'b1, r_sel, code[7:0]);
            ev_en <= 1'b1;
            apb(1'b1, r_mode, 8'h80);
            wait_for(1'b0, 1'b1, c);
            wait_for(1'b0, 1'b1, c);
            chk(c, 48);
            apb(1'b1, r_mode, 8'h00);
            ev_en <= 1'b0;
        end
        $display("event count done");
        final_report;
    end
endmodule // eight_bit_event_timer_tb
